//--- design/watchdog_periodic_interrupt_timer.v
// watchdog and periodic interrupt timer on the low byte of the peripheral bus
//
// Behaviour
// - 8-bit watchdog counter, cleared by key or reset
// - overflow resets one counter clock later
// - 7-bit prescaler free-runs, reset clears only
// - counter clears leave prescaler untouched
// - rate select: six taps, two direct codes
// - overflow period 15.63 ms to 1 s
// - key 55h arms clear, repeats harmless
// - key aah clears when armed, else nothing
// - any other key value forces reset
// - overflow or bad key sets cause flag
// - set cause flag never blocks resets
// - runs whenever timebase clock runs
// - software cannot disable overflow reset
// - disabled only by strap plus defeat bit
// - counter readable anytime without disturbance
// - control writes need guard pattern 101
// - counting starts right after reset release
// - registers occupy low byte only
// - periodic select: four plus four taps
// - enable bit gates periodic interrupt request
// - periodic flag sets on selected overflow
// - control layout: flag, defeat, guard, rate
// - periodic control: flag, enable, rate
`include "wd_rti_map.vh"
`timescale 1ns/1ns
`default_nettype none
module watchdog_periodic_interrupt_timer (
  input wire mclk_i,
  input wire rst_n_i,
  input wire slow_timebase_clock_i,
  input wire program_voltage_pin_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg system_reset_o,
  output reg periodic_interrupt_o
);

  // true when the low n bits of v are all ones
  function ones_below;
    input [7:0] v;
    input [3:0] n;
    integer i;
    begin
      ones_below = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        if ((i < n) && !v[i]) begin
          ones_below = 1'b0;
        end
      end
    end
  endfunction

  wire [1:0] sync_q;
  reg tb_prev;
  reg [6:0] free_count;
  reg [7:0] watchdog_count;
  reg [7:0] periodic_tick_count;
  reg armed;
  reg overflow_pending;
  reg watchdog_cause_flag;
  reg watchdog_defeat_bit;
  reg [2:0] watchdog_guard_bits;
  reg [2:0] watchdog_rate_select;
  reg periodic_overflow_flag;
  reg periodic_irq_enable;
  reg [2:0] periodic_rate_select;
  reg [3:0] pulse_count;
  reg [1:0] strap_wait;
  reg strap_high;

  sync_pair u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i({program_voltage_pin_i, slow_timebase_clock_i}),
    .q_o(sync_q)
  );

  wire tick = sync_q[0] & ~tb_prev;
  wire [7:0] wbyte = wdata_i[7:0];
  wire wr_per_count = wr_i && (addr_i == `PERIODIC_TICK_COUNTER_ADDR);
  wire wr_key = wr_i && (addr_i == `WATCHDOG_SERVICE_KEY_ADDR);
  wire wr_per_ctrl = wr_i && (addr_i == `PERIODIC_IRQ_CONTROL_ADDR);
  wire wr_wd_ctrl = wr_i && (addr_i == `WATCHDOG_CONTROL_ADDR);

  // strap and defeat bit both needed
  wire wd_disabled = strap_high & watchdog_defeat_bit;

  reg wd_step;
  always @* begin
    wd_step = 1'b0;
    case (watchdog_rate_select)
      3'h0, 3'h1: wd_step = tick;
      default: wd_step = tick & ones_below({1'b0, free_count},
                                           {1'b0, watchdog_rate_select - `WD_TAP_OFFSET});
    endcase
  end

  // free taps then periodic counter taps
  wire per_base = tick & ones_below({1'b0, free_count}, `PER_BASE_TAP);
  reg per_event;
  always @* begin
    per_event = 1'b0;
    case (periodic_rate_select)
      3'h0: per_event = tick & ones_below({1'b0, free_count}, `PER_TAP0);
      3'h1: per_event = tick & ones_below({1'b0, free_count}, `PER_TAP1);
      3'h2: per_event = tick & ones_below({1'b0, free_count}, `PER_TAP2);
      3'h3: per_event = tick & ones_below({1'b0, free_count}, `PER_TAP3);
      3'h4: per_event = per_base & ones_below(periodic_tick_count, `PER_TAP4);
      3'h5: per_event = per_base & ones_below(periodic_tick_count, `PER_TAP5);
      3'h6: per_event = per_base & ones_below(periodic_tick_count, `PER_TAP6);
      default: per_event = per_base & ones_below(periodic_tick_count, `PER_TAP7);
    endcase
  end

  wire key_bad = wr_key && (wbyte != `KEY_ARM) && (wbyte != `KEY_CLEAR);
  // fire on the next counter clock after wrap
  wire ovf_fire = wd_step & overflow_pending;
  wire guard_bad = (watchdog_guard_bits != `GUARD_PATTERN) ||
                   (wr_wd_ctrl && (wbyte[`GUARD_HI:`GUARD_LO] != `GUARD_PATTERN));
  // flag state plays no part here
  wire wd_cause = (ovf_fire | key_bad) & ~wd_disabled;
  wire fire = (wd_cause | guard_bad) & ~system_reset_o;

  // reset pulse generator
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_count <= 4'h0;
      system_reset_o <= 1'b0;
    end else if (fire) begin
      pulse_count <= `RST_PULSE_CYCLES;
      system_reset_o <= 1'b1;
    end else if (pulse_count != 4'h0) begin
      pulse_count <= pulse_count - 4'h1;
      system_reset_o <= (pulse_count > 4'h1);
    end
  end

  // strap caught during each reset sequence
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_wait <= 2'h0;
      strap_high <= 1'b0;
    end else if (strap_wait != `STRAP_SETTLE) begin
      strap_wait <= strap_wait + 2'h1;
      strap_high <= sync_q[1];
    end else if (system_reset_o) begin
      strap_high <= sync_q[1];
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_prev <= 1'b0;
    end else begin
      tb_prev <= sync_q[0];
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      free_count <= 7'h0;
    end else if (system_reset_o) begin
      free_count <= 7'h0;
    end else if (tick) begin
      free_count <= free_count + 7'h1;
    end
  end

  // watchdog counter, key logic and control register
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_count <= 8'h0;
      armed <= 1'b0;
      overflow_pending <= 1'b0;
      watchdog_defeat_bit <= 1'b0;
      watchdog_guard_bits <= `GUARD_PATTERN;
      watchdog_rate_select <= `WD_RATE_RESET;
    end else if (system_reset_o) begin
      // arm and count cleared by system reset
      watchdog_count <= 8'h0;
      armed <= 1'b0;
      overflow_pending <= 1'b0;
      watchdog_defeat_bit <= 1'b0;
      watchdog_guard_bits <= `GUARD_PATTERN;
      watchdog_rate_select <= `WD_RATE_RESET;
    end else begin
      if (wr_key && (wbyte == `KEY_ARM)) begin
        armed <= 1'b1;
      end
      if (wr_key && (wbyte == `KEY_CLEAR) && armed) begin
        watchdog_count <= 8'h0;
        armed <= 1'b0;
      end else if (wd_step && !wd_disabled) begin
        watchdog_count <= watchdog_count + 8'h1;
        if (watchdog_count == 8'hff) begin
          overflow_pending <= 1'b1;
        end
      end
      if (wr_wd_ctrl) begin
        watchdog_defeat_bit <= wbyte[`DEFEAT_BIT];
        watchdog_guard_bits <= wbyte[`GUARD_HI:`GUARD_LO];
        watchdog_rate_select <= wbyte[`RATE_HI:`RATE_LO];
      end
    end
  end

  // cause flag survives the pulse, cleared by power-on reset or a control write with bit 7 low
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_cause_flag <= 1'b0;
    end else if (wd_cause) begin
      watchdog_cause_flag <= 1'b1;
    end else if (wr_wd_ctrl && !wbyte[`CAUSE_FLAG_BIT] && !system_reset_o) begin
      watchdog_cause_flag <= 1'b0;
    end
  end

  // periodic counter, flag and interrupt
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periodic_tick_count <= 8'h0;
      periodic_overflow_flag <= 1'b0;
      periodic_irq_enable <= 1'b0;
      periodic_rate_select <= `PER_RATE_RESET;
      periodic_interrupt_o <= 1'b0;
    end else if (system_reset_o) begin
      periodic_tick_count <= 8'h0;
      periodic_overflow_flag <= 1'b0;
      periodic_irq_enable <= 1'b0;
      periodic_rate_select <= `PER_RATE_RESET;
      periodic_interrupt_o <= 1'b0;
    end else begin
      if (wr_per_count) begin
        periodic_tick_count <= 8'h0;
      end else if (per_base) begin
        periodic_tick_count <= periodic_tick_count + 8'h1;
      end
      // flag set on selected tap, set wins
      if (per_event) begin
        periodic_overflow_flag <= 1'b1;
      end else if (wr_per_ctrl) begin
        periodic_overflow_flag <= wbyte[`PER_FLAG_BIT];
      end
      if (wr_per_ctrl) begin
        periodic_irq_enable <= wbyte[`PER_ENABLE_BIT];
        periodic_rate_select <= wbyte[`RATE_HI:`RATE_LO];
      end
      periodic_interrupt_o <= per_event & periodic_irq_enable;
    end
  end

  // read mux, answered one cycle after rd_i
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0;
    end else if (rd_i) begin
      // low byte only, upper byte zero
      rdata_o[15:8] <= 8'h0;
      case (addr_i)
        `PERIODIC_TICK_COUNTER_ADDR: rdata_o[7:0] <= periodic_tick_count;
        `WATCHDOG_COUNTER_ADDR: rdata_o[7:0] <= watchdog_count;
        `PERIODIC_IRQ_CONTROL_ADDR: rdata_o[7:0] <= {periodic_overflow_flag, periodic_irq_enable,
                                                     3'h0, periodic_rate_select};
        `WATCHDOG_CONTROL_ADDR: rdata_o[7:0] <= {watchdog_cause_flag, watchdog_defeat_bit,
                                                 watchdog_guard_bits, watchdog_rate_select};
        default: rdata_o[7:0] <= 8'h0;
      endcase
    end else begin
      rdata_o <= 16'h0;
    end
  end

  // direct tap at the timebase gives 256 ticks per overflow
  // counting needs no setup after release
endmodule
`default_nettype wire

//--- design/wd_rti_map.vh
// register map, field positions, keys and timing counts of the watchdog timer
`ifndef WD_RTI_MAP_VH
`define WD_RTI_MAP_VH
`define PERIODIC_TICK_COUNTER_ADDR 16'h7021
`define WATCHDOG_COUNTER_ADDR 16'h7023
`define WATCHDOG_SERVICE_KEY_ADDR 16'h7025
`define PERIODIC_IRQ_CONTROL_ADDR 16'h7027
`define WATCHDOG_CONTROL_ADDR 16'h7029
`define CAUSE_FLAG_BIT 7
`define DEFEAT_BIT 6
`define GUARD_HI 5
`define GUARD_LO 3
`define RATE_HI 2
`define RATE_LO 0
`define PER_FLAG_BIT 7
`define PER_ENABLE_BIT 6
`define GUARD_PATTERN 3'h5
`define KEY_ARM 8'h55
`define KEY_CLEAR 8'haa
`define WD_RATE_RESET 3'h0
`define PER_RATE_RESET 3'h0
`define TIMEBASE_HZ 16384
`define WD_TAP_OFFSET 3'h1
`define PER_BASE_TAP 4'h7
`define PER_TAP0 4'h2
`define PER_TAP1 4'h4
`define PER_TAP2 4'h6
`define PER_TAP3 4'h7
`define PER_TAP4 4'h1
`define PER_TAP5 4'h3
`define PER_TAP6 4'h5
`define PER_TAP7 4'h7
`define RST_PULSE_CYCLES 4'h8
`define STRAP_SETTLE 2'h3
`endif

//--- design/sync_pair.v
// two-flop synchroniser for two independent pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync_pair (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [1:0] d_i,
  output reg [1:0] q_o
);
  reg [1:0] meta;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 2'h0;
      q_o <= 2'h0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

//--- testbench/wd_timer_props.sv
// port checker for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "wd_rti_map.vh"
module wd_timer_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic program_voltage_pin_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic system_reset_o,
  input wire logic periodic_interrupt_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire key_wr = wr_i && addr_i == `WATCHDOG_SERVICE_KEY_ADDR && !system_reset_o;
  wire ctl_wr = wr_i && addr_i == `WATCHDOG_CONTROL_ADDR && !system_reset_o;
  sequence s_pulse;
    system_reset_o [*8] ##1 !system_reset_o;
  endsequence
  sequence s_serve;
    key_wr && wdata_i[7:0] == `KEY_ARM ##2 key_wr && wdata_i[7:0] == `KEY_CLEAR;
  endsequence
  a_bad_key_reset: assert property (
    key_wr && !program_voltage_pin_i && wdata_i[7:0] != `KEY_ARM && wdata_i[7:0] != `KEY_CLEAR |=> s_pulse)
    else $error("bad key kept");
  a_bad_guard_reset: assert property (
    ctl_wr && wdata_i[5:3] != `GUARD_PATTERN |=> s_pulse) else $error("bad guard kept");
  a_reset_pulse_len: assert property (
    $rose(system_reset_o) |-> s_pulse) else $error("reset pulse length");
  a_serve_no_reset: assert property (
    s_serve |=> !system_reset_o) else $error("service caused reset");
  a_serve_clears_count: assert property (
    s_serve ##2 (rd_i && addr_i == `WATCHDOG_COUNTER_ADDR) |=> rdata_o[7:1] == 7'h00) else $error("count not cleared");
  a_upper_byte_zero: assert property (
    rdata_o[15:8] == 8'h00) else $error("upper byte set");
  a_idle_read_zero: assert property (
    !rd_i |=> rdata_o == 16'h0000) else $error("read data lingers");
  a_irq_single_pulse: assert property (
    periodic_interrupt_o |=> !periodic_interrupt_o) else $error("irq too long");
endmodule
bind watchdog_periodic_interrupt_timer wd_timer_props wd_timer_props_u (.mclk_i, .rst_n_i, .program_voltage_pin_i,
  .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .system_reset_o, .periodic_interrupt_o);
`default_nettype wire

//--- testbench/watchdog_periodic_interrupt_timer_test.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "wd_rti_map.vh"
module watchdog_periodic_interrupt_timer_test;
  logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic [15:0] addr_i = 0, wdata_i = 0;
  logic [2:0] div = 0;
  logic strap = 0;
  logic [7:0] v;
  logic [7:0] keys [10] = '{8'haa, 8'haa, 8'h55, 8'h55, 8'h55, 8'haa, 8'haa, 8'h55, 8'haa, 8'h55};
  wire [15:0] rdata_o;
  wire system_reset_o, periodic_interrupt_o;
  integer errors = 0, tests_run = 0, seed = 88, n = 0, irqs = 0, i;
  logic [15:0] expq[$];
  logic [7:0] tolq[$];
  watchdog_periodic_interrupt_timer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_timebase_clock_i(div[2]),
    .program_voltage_pin_i(strap), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .system_reset_o(system_reset_o), .periodic_interrupt_o(periodic_interrupt_o));
  always #4 mclk_i = ~mclk_i;
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // timebase ticks every 8 cycles, read results from the queue
  always @(posedge mclk_i) begin
    div <= div + 3'h1;
    rd_d <= rd_i;
    if (periodic_interrupt_o === 1'b1)
      irqs = irqs + 1;
    if (rd_d === 1'b1) begin
      check("rdata", (rdata_o > expq[0] + tolq[0] || rdata_o + tolq[0] < expq[0]) ? rdata_o : expq[0], expq[0]);
      void'(expq.pop_front());
      void'(tolq.pop_front());
    end
  end
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e, input logic [7:0] t);
    expq.push_back(e);
    tolq.push_back(t);
    @(posedge mclk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 0;
  endtask
  task serve;
    wr(`WATCHDOG_SERVICE_KEY_ADDR, 16'h0055);
    wr(`WATCHDOG_SERVICE_KEY_ADDR, 16'h00aa);
    rd(`WATCHDOG_COUNTER_ADDR, 16'h0000, 8'h1);
  endtask
  task rst_wait(input logic exp, input integer lim);
    n = 0;
    while (system_reset_o !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n = n + 1;
    end
    check("reset", {15'h0, system_reset_o}, {15'h0, exp});
    if (exp && n == lim)
      complete_run;
    repeat (12) @(posedge mclk_i);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1;
    rd(`WATCHDOG_CONTROL_ADDR, 16'h0028, 8'h0);
    rd(16'h7020, 16'h0000, 8'h0);
    wr(`WATCHDOG_CONTROL_ADDR, 16'hff2a);
    rd(`WATCHDOG_CONTROL_ADDR, 16'h002a, 8'h0);
    $display("done regs");
    for (i = 0; i < 10; i = i + 1)
      wr(`WATCHDOG_SERVICE_KEY_ADDR, {8'h00, keys[i]});
    serve;
    rst_wait(0, 20);
    wr(`WATCHDOG_SERVICE_KEY_ADDR, 16'h0023);
    rst_wait(1, 20);
    rd(`WATCHDOG_CONTROL_ADDR, 16'h00a8, 8'h0);
    $display("done keys");
    for (i = 0; i < 8; i = i + 1) begin
      wr(`WATCHDOG_CONTROL_ADDR, 16'h0028 | i[15:0]);
      serve;
      repeat (1024) @(posedge mclk_i);
      rd(`WATCHDOG_COUNTER_ADDR, (i < 2) ? 16'd128 : 16'd128 >> (i - 1), 8'h1);
    end
    $display("done rates");
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0028);
    serve;
    rst_wait(1, 2300);
    check("ovf_time", {15'h0, n > 2030}, 16'h0001);
    rd(`WATCHDOG_CONTROL_ADDR, 16'h00a8, 8'h0);
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0028);
    rd(`WATCHDOG_CONTROL_ADDR, 16'h0028, 8'h0);
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0010);
    rst_wait(1, 20);
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0068);
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      if (v == 8'h55 || v == 8'haa)
        v = 8'h00;
      wr(`WATCHDOG_SERVICE_KEY_ADDR, {8'h00, v});
      rst_wait(1, 20);
    end
    strap <= 1'b1;
    wr(`WATCHDOG_SERVICE_KEY_ADDR, 16'h0023);
    rst_wait(1, 20);
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0068);
    wr(`WATCHDOG_SERVICE_KEY_ADDR, 16'h0023);
    rst_wait(0, 20);
    strap <= 1'b0;
    wr(`WATCHDOG_CONTROL_ADDR, 16'h0010);
    rst_wait(1, 20);
    $display("done resets");
    wr(`PERIODIC_IRQ_CONTROL_ADDR, 16'h0040);
    irqs = 0;
    repeat (320) @(posedge mclk_i);
    check("irqs", {15'h0, irqs >= 9 && irqs <= 11}, 16'h0001);
    rd(`PERIODIC_IRQ_CONTROL_ADDR, 16'h00c0, 8'h0);
    wr(`PERIODIC_IRQ_CONTROL_ADDR, 16'h0000);
    irqs = 0;
    repeat (320) @(posedge mclk_i);
    check("irqs_off", irqs[15:0], 16'h0000);
    wr(`PERIODIC_TICK_COUNTER_ADDR, 16'h0077);
    rd(`PERIODIC_TICK_COUNTER_ADDR, 16'h0000, 8'h1);
    repeat (3) @(posedge mclk_i);
    $display("done periodic");
    complete_run;
  end
endmodule
`default_nettype wire
